// File: dccr_top.sv
// Operation
// - address 010 selects the mode_control register
// - feedback bit 0: amplifier on, series resistors
// - feedback bit 1: amplifier off, parallel resistors
// - clamp bit 0: release clamp, normal mode
// - clamp bit 1: clamp output, converter tristated
// - reset gives clamped, tristated output
// - clamp set overrides the tristate bit
// - tristate bit 1 tristates, 0 normal
// - format bit 0 twos complement, 1 binary
// - serial out disable bit tristates output pin
// - top frame bit: 0 write, 1 read
// - clear pin or bit loads clearcode
// - clearcode resets to zero
// - clearcode uses the current code format
// - control read returns contents next transfer
// - read data shifts out over 24 clocks
`timescale 1ns/1ps
`default_nettype none
`include "dccr_map.svh"

module dccr_top #(
  parameter int CODE_W = 18
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // serial link pins
  input  wire logic              serial_clk,
  input  wire logic              frame_sync_n,
  input  wire logic              serial_data_in,
  output var  logic              serial_data_out,
  output var  logic              serial_data_out_oe,
  // clear pin
  input  wire logic              output_clear_input_n,
  // analog path controls
  output var  logic              internal_amplifier_on,
  output var  logic              feedback_resistor_parallel,
  output var  logic              output_ground_clamp,
  output var  logic              converter_tristate,
  output var  logic              code_format_select,
  output var  logic [CODE_W-1:0] converter_code
);

  if (CODE_W < 2 || CODE_W > 19)
  begin : g_chk
    $error("CODE_W must lie between 2 and 19");
  end

  function automatic logic addr_is(dccr_pkg::dccr_addr_t a, dccr_pkg::dccr_addr_t code);
    addr_is = (a == code);
  endfunction

  // ************************************************************
  // pin synchronisation and edge detection
  // ************************************************************
  logic [3:0] pins_s;
  logic       sclk_s;
  logic       sync_s;
  logic       sdin_s;
  logic       clear_s;
  logic       sclk_p_q;
  logic       sync_p_q;

  dccr_sync #(
    .WIDTH   (4),
    .RST_VAL (4'hB)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({output_clear_input_n, serial_data_in, frame_sync_n, serial_clk}),
    .sync_out (pins_s)
  );

  assign sclk_s = pins_s[0];
  assign sync_s = pins_s[1];
  assign sdin_s = pins_s[2];
  assign clear_s = pins_s[3];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclk_p_q <= 1'b1;
      sync_p_q <= 1'b1;
    end
    else
    begin
      sclk_p_q <= sclk_s;
      sync_p_q <= sync_s;
    end
  end

  wire sclk_fall = sclk_p_q & ~sclk_s;
  wire sync_fall = sync_p_q & ~sync_s;
  wire sync_rise = ~sync_p_q & sync_s;
  wire in_frame  = ~sync_s;

  // ************************************************************
  // input shift register and frame counter
  // ************************************************************
  dccr_pkg::dccr_frame_t shift_q;
  dccr_pkg::dccr_frame_t shift_d;
  dccr_pkg::dccr_cnt_t   cnt_q;
  dccr_pkg::dccr_cnt_t   cnt_d;

  wire take_bit = sclk_fall & in_frame;
  assign shift_d = take_bit ? {shift_q[22:0], sdin_s} : shift_q;
  assign cnt_d   = sync_fall ? 5'h00 :
                   (take_bit && cnt_q != `DCCR_CNT_MAX) ? cnt_q + 5'h01 : cnt_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_q <= 24'h000000;
      cnt_q   <= 5'h00;
    end
    else
    begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  // ************************************************************
  // frame decode
  // ************************************************************
  dccr_pkg::dccr_addr_t addr;
  logic [CODE_W-1:0]    wdata;

  assign addr  = shift_q[`DCCR_ADDR_HI:`DCCR_ADDR_LO];
  assign wdata = shift_q[`DCCR_DATA_HI -: CODE_W];

  wire frame_ok = sync_rise & (cnt_q == `DCCR_FRAME_LEN);
  wire wr       = frame_ok & ~shift_q[`DCCR_RW_BIT];
  wire rd       = frame_ok & shift_q[`DCCR_RW_BIT];
  wire ctrl_we  = wr & addr_is(addr, `DCCR_ADDR_CTRL);
  wire clrc_we  = wr & addr_is(addr, `DCCR_ADDR_CLRC);
  wire dac_we   = wr & addr_is(addr, `DCCR_ADDR_DAC);
  wire sw_clr   = wr & addr_is(addr, `DCCR_ADDR_SWCTL) & shift_q[`DCCR_SW_CLEAR_BIT];
  wire clear_rq = ~clear_s | sw_clr;

  // ************************************************************
  // registers
  // ************************************************************
  dccr_pkg::dccr_ctrl_t ctrl_q;
  dccr_pkg::dccr_ctrl_t ctrl_d;
  logic [CODE_W-1:0]    clrc_q;
  logic [CODE_W-1:0]    clrc_d;
  logic [CODE_W-1:0]    dac_q;
  logic [CODE_W-1:0]    dac_d;

  // reserved positions are not stored, host keeps them zero
  assign ctrl_d = ctrl_we ? (shift_q[5:0] & `DCCR_CTRL_MASK) : ctrl_q;
  assign clrc_d = clrc_we ? wdata : clrc_q;
  // clear wins; no update while clear pin is held
  assign dac_d  = clear_rq ? clrc_q : (dac_we ? wdata : dac_q);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_q <= `DCCR_CTRL_RST;
      clrc_q <= CODE_W'(`DCCR_CLRC_RST);
      dac_q  <= '0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      clrc_q <= clrc_d;
      dac_q  <= dac_d;
    end
  end

  // ************************************************************
  // readback
  // ************************************************************
  logic [19:0]           payload;
  dccr_pkg::dccr_frame_t rd_q;
  dccr_pkg::dccr_frame_t rd_d;

  assign payload = addr_is(addr, `DCCR_ADDR_CTRL) ? {14'h0000, ctrl_q} :
                   addr_is(addr, `DCCR_ADDR_CLRC) ? {clrc_q, {(20-CODE_W){1'b0}}} :
                   addr_is(addr, `DCCR_ADDR_DAC)  ? {dac_q, {(20-CODE_W){1'b0}}} :
                   20'h00000;
  assign rd_d = rd        ? {1'b1, addr, payload} :
                sync_rise ? 24'h000000 :
                take_bit  ? {rd_q[22:0], 1'b0} : rd_q;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rd_q <= 24'h000000;
    else
      rd_q <= rd_d;
  end

  // ************************************************************
  // output flops
  // ************************************************************
  wire fmt = ctrl_q[`DCCR_FMT_BIT];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      serial_data_out            <= 1'b0;
      serial_data_out_oe         <= 1'b0;
      internal_amplifier_on      <= 1'b0;
      feedback_resistor_parallel <= 1'b1;
      output_ground_clamp        <= 1'b1;
      converter_tristate         <= 1'b1;
      code_format_select         <= 1'b0;
      converter_code             <= '0;
    end
    else
    begin
      serial_data_out            <= rd_q[23];
      serial_data_out_oe         <= in_frame & ~ctrl_q[`DCCR_SOUT_DIS_BIT];
      internal_amplifier_on      <= ~ctrl_q[`DCCR_AMP_FB_BIT];
      feedback_resistor_parallel <= ctrl_q[`DCCR_AMP_FB_BIT];
      output_ground_clamp        <= ctrl_q[`DCCR_CLAMP_BIT];
      converter_tristate         <= ctrl_q[`DCCR_CLAMP_BIT] | ctrl_q[`DCCR_TRI_BIT];
      code_format_select         <= fmt;
      // level in offset binary; twos complement flips the sign bit
      converter_code             <= dac_q ^ {~fmt, {(CODE_W-1){1'b0}}};
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_ctrl_read;
    rd && addr == `DCCR_ADDR_CTRL;
  endsequence

  sequence s_bad_frame;
    sync_rise && cnt_q != `DCCR_FRAME_LEN;
  endsequence

  ctrl_write_a: assert property (ctrl_we |=> ctrl_q == ($past(shift_q[5:0]) & 6'h3E))
    else $error("control write not stored");
  fb_series_a: assert property (!ctrl_q[1] ##1 !ctrl_q[1] |-> internal_amplifier_on && !feedback_resistor_parallel)
    else $error("series feedback not selected");
  fb_parallel_a: assert property (ctrl_q[1] ##1 ctrl_q[1] |-> !internal_amplifier_on && feedback_resistor_parallel)
    else $error("parallel feedback not selected");
  clamp_release_a: assert property (!ctrl_q[2] |=> !output_ground_clamp)
    else $error("clamp not released");
  clamp_hold_a: assert property (ctrl_q[2] |=> output_ground_clamp && converter_tristate)
    else $error("clamp does not force tristate");
  reset_state_a: assert property ($rose(nrst) |-> output_ground_clamp && converter_tristate && ctrl_q == 6'h0E)
    else $error("reset state not clamped");
  tri_mode_a: assert property (!ctrl_q[2] |=> converter_tristate == $past(ctrl_q[3]))
    else $error("tristate bit ignored");
  code_fmt_a: assert property (dac_q == '0 |=> converter_code[CODE_W-1] == !$past(ctrl_q[4]))
    else $error("code format not applied");
  sdo_disable_a: assert property (ctrl_q[5] |=> !serial_data_out_oe)
    else $error("serial output not disabled");
  clear_load_a: assert property (!clear_s |=> dac_q == $past(clrc_q))
    else $error("clear did not load clearcode");
  ctrl_read_a: assert property (s_ctrl_read |=> rd_q == {4'hA, 14'h0000, $past(ctrl_q)} ##2 serial_data_out)
    else $error("control readback wrong");
  bad_frame_a: assert property (s_bad_frame |=> $stable(ctrl_q) && $stable(clrc_q))
    else $error("short or long frame changed a register");

endmodule

`default_nettype wire

// File: dccr_map.svh
`ifndef DCCR_MAP_SVH
`define DCCR_MAP_SVH

// ************************************************************
// frame layout
// ************************************************************
`define DCCR_FRAME_LEN   5'h18
`define DCCR_CNT_MAX     5'h1F
`define DCCR_RW_BIT      23
`define DCCR_ADDR_HI     22
`define DCCR_ADDR_LO     20
`define DCCR_DATA_HI     19

// ************************************************************
// register addresses
// ************************************************************
`define DCCR_ADDR_NOP    3'h0
`define DCCR_ADDR_DAC    3'h1
`define DCCR_ADDR_CTRL   3'h2
`define DCCR_ADDR_CLRC   3'h3
`define DCCR_ADDR_SWCTL  3'h4

// ************************************************************
// mode_control fields and reset
// ************************************************************
`define DCCR_AMP_FB_BIT   1
`define DCCR_CLAMP_BIT    2
`define DCCR_TRI_BIT      3
`define DCCR_FMT_BIT      4
`define DCCR_SOUT_DIS_BIT 5
`define DCCR_CTRL_MASK   6'h3E
`define DCCR_CTRL_RST    6'h0E
`define DCCR_CLRC_RST    18'h00000
`define DCCR_SW_CLEAR_BIT 1

`endif

// File: dccr_pkg.sv
`default_nettype none

package dccr_pkg;
  typedef logic [23:0] dccr_frame_t;
  typedef logic [2:0]  dccr_addr_t;
  typedef logic [5:0]  dccr_ctrl_t;
  typedef logic [4:0]  dccr_cnt_t;
endpackage

`default_nettype wire

// File: dccr_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-stage synchroniser, one per bit
module dccr_sync #(
  parameter int    WIDTH = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge nrst)
    begin
      if (!nrst)
      begin
        meta_q[i]   <= RST_VAL[i];
        sync_out[i] <= RST_VAL[i];
      end
      else
      begin
        meta_q[i]   <= async_in[i];
        sync_out[i] <= meta_q[i];
      end
    end
  end
endmodule

`default_nettype wire

// File: dccr_host.sv
`timescale 1ns/1ps
`default_nettype none

// ****************
// host serial side
// ****************
module dccr_host (
  // link pins
  output var  logic serial_clk,
  output var  logic frame_sync_n,
  output var  logic serial_data_in,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe
);
  logic oe_seen;

  initial
  begin
    serial_clk     = 1'b1;
    frame_sync_n   = 1'b1;
    serial_data_in = 1'b0;
    oe_seen        = 1'b0;
  end

  // one frame of n falling edges, msb first, clock idle high
  task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx           = 24'h000000;
    frame_sync_n = 1'b0;
    #160;
    for (int i = 0; i < n; i++)
    begin
      serial_data_in = (i < 24) ? tx[23-i] : 1'b0;
      #80;
      serial_clk = 1'b0;
      oe_seen    = serial_data_out_oe;
      // released pin reads back as the inverse of the last driven bit
      rx         = {rx[22:0], serial_data_out_oe ? serial_data_out : ~serial_data_out};
      #80;
      serial_clk = 1'b1;
    end
    frame_sync_n   = 1'b1;
    serial_data_in = ~serial_data_in;
    #200;
  endtask
endmodule

`default_nettype wire

// File: dac_control_clearcode_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

// *********
// testbench
// *********
module dac_control_clearcode_regs_tb;
  logic        clk, nrst, sclk, fs_n, sdi, sd_out, sd_out_oe, clear_n;
  logic        amp, par, clamp, tri_o, fmt;
  logic [17:0] code;
  logic [23:0] rx;
  logic [5:0]  tbl [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h02, 6'h10, 6'h20, 6'h3E};
  int          num_errors, compares, ctrl_m, clrc_m, dac_m, d, v;

  dccr_top i_dut (.clk(clk), .nrst(nrst), .serial_clk(sclk), .frame_sync_n(fs_n),
    .serial_data_in(sdi), .serial_data_out(sd_out), .serial_data_out_oe(sd_out_oe),
    .output_clear_input_n(clear_n), .internal_amplifier_on(amp),
    .feedback_resistor_parallel(par), .output_ground_clamp(clamp),
    .converter_tristate(tri_o), .code_format_select(fmt), .converter_code(code));
  dccr_host i_host (.serial_clk(sclk), .frame_sync_n(fs_n), .serial_data_in(sdi),
    .serial_data_out(sd_out), .serial_data_out_oe(sd_out_oe));

  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_pins();
    logic [4:0] e;
    e = {~ctrl_m[1], ctrl_m[1], ctrl_m[2], ctrl_m[2] | ctrl_m[3], ctrl_m[4]};
    chk_word({19'h0, amp, par, clamp, tri_o, fmt}, {19'h0, e});
  endtask

  task automatic chk_code();
    int e;
    e = ctrl_m[4] ? dac_m : dac_m ^ 'h20000;
    chk_word({6'h0, code}, e[23:0]);
  endtask

  task automatic xfer(input logic [23:0] tx, input int n);
    #1;
    i_host.frame(tx, n, rx);
    repeat (10) @(posedge clk);
  endtask

  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    #600000;
    num_errors++;
    test_done();
  end

  initial
  begin
    nrst       = 1'b0;
    clear_n    = 1'b1;
    num_errors = 0;
    compares   = 0;
    ctrl_m     = 'h0E;
    clrc_m     = 0;
    dac_m      = 0;
    void'($urandom(29282));
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    chk_pins();
    xfer(24'hA00000, 24);
    xfer(24'h000000, 24);
    chk_word(rx, 24'hA0000E);
    xfer(24'hB00000, 24);
    xfer(24'h000000, 24);
    chk_word(rx, 24'hB00000);
    $display("reset test done");
    for (int i = 0; i < 12; i++)
    begin
      d = (i < 8) ? tbl[i] : ($urandom & 'h3E);
      xfer({4'h2, 14'h0, d[5:0]}, 24);
      ctrl_m = d;
      chk_pins();
      xfer(24'hA00000, 24);
      xfer(24'h000000, 24);
      chk_word({23'h0, i_host.oe_seen}, {23'h0, ~d[5]});
      chk_word(rx, d[5] ? ~{4'hA, 14'h0, d[5:0]} : {4'hA, 14'h0, d[5:0]});
    end
    $display("control test done");
    xfer({4'h2, 14'h0, ~ctrl_m[5:0] & 6'h3E}, 23);
    xfer({4'h2, 14'h0, ~ctrl_m[5:0] & 6'h3E}, 25);
    chk_pins();
    $display("length test done");
    for (int f = 0; f < 2; f++)
    begin
      ctrl_m = f << 4;
      xfer({4'h2, 14'h0, ctrl_m[5:0]}, 24);
      v = $urandom & 'h3FFFF;
      xfer({4'h3, v[17:0], 2'b00}, 24);
      clrc_m = v;
      d = $urandom & 'h3FFFF;
      xfer({4'h1, d[17:0], 2'b00}, 24);
      dac_m = d;
      chk_code();
      @(posedge clk);
      #1 clear_n = 1'b0;
      repeat (8) @(posedge clk);
      dac_m = clrc_m;
      chk_code();
      #1 clear_n = 1'b1;
      repeat (8) @(posedge clk);
      chk_code();
      xfer({4'h1, d[17:0] ^ 18'h00F00, 2'b00}, 24);
      xfer(24'h400002, 24);
      chk_code();
      xfer(24'hB00000, 24);
      xfer(24'h000000, 24);
      chk_word(rx, {4'hB, clrc_m[17:0], 2'b00});
    end
    $display("clear test done");
    test_done();
  end
endmodule

`default_nettype wire
